// file: verilog/octp_defs.vh
`ifndef OCTP_DEFS_VH
`define OCTP_DEFS_VH
// ----------------------------------------------------------------
// clock and timing
// ----------------------------------------------------------------
`define OCTP_CLK_MHZ        200
`define OCTP_QUAL_US        100
`define OCTP_QUAL_CYC       (`OCTP_QUAL_US * `OCTP_CLK_MHZ)
`define OCTP_REMOTE_MAX_MS  200
`define OCTP_TRIG_MAX_US    500
`define OCTP_SD_MAX_US      100
// ----------------------------------------------------------------
// remote switch modes
// ----------------------------------------------------------------
`define OCTP_MODE_W         2
`define OCTP_MODE_LEVEL     2'h0
`define OCTP_MODE_IGNORE    2'h1
`define OCTP_MODE_STANDBY   2'h2
// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define OCTP_ADDR_W         4
`define OCTP_REG_CTRL       4'h0
`define OCTP_REG_CMD        4'h1
`define OCTP_REG_PULSE      4'h2
`define OCTP_REG_STATUS     4'h3
`define OCTP_REG_IRQ_STAT   4'h4
`define OCTP_REG_IRQ_MASK   4'h5
// ctrl fields
`define OCTP_CTRL_MODE_LSB  0
`define OCTP_CTRL_INVERT    2
`define OCTP_CTRL_TRIG_LVL  3
// command bits, write-only pulses
`define OCTP_CMD_ON         0
`define OCTP_CMD_OFF        1
`define OCTP_CMD_LIST_SET   2
`define OCTP_CMD_LIST_CLR   3
`define OCTP_CMD_TRIG_OUT   4
// event bits
`define OCTP_EV_TRIG        0
`define OCTP_EV_SHUTDOWN    1
`define OCTP_EV_STANDBY     2
`define OCTP_EV_W           3
`endif

// file: verilog/octp_top.v
// Summary of operation
// - Default: low remote input disables output, high or open enables it.
// - A configuration bit inverts the remote input polarity.
// - Ignore mode: output follows only the on and off commands.
// - Standby mode: low held 100 us disables output, enters standby.
// - In standby, remote going high never re-enables; only on command.
// - Remote input changes are acted on within 200 ms.
// - Trigger low held 100 us gives exactly one event; shorter ignored.
// - No further trigger until the trigger input returns high.
// - A qualified trigger is answered within 500 us.
// - Shutdown input removes output, keeps powered, fault lamp red.
// - Shutdown completes within 100 us of assertion.
// - Shutdown stays latched until a full power cycle.
// - Power-good flag conducts in normal operation, released otherwise.
// - Output-off flag conducts while output disabled, off while enabled.
// - List trigger setup repurposes output-off flag as trigger output.
// - Trigger output active level and pulse width come from setup values.
// - List clear returns output-off flag to output state reporting.
`timescale 1ns/1ps
`default_nettype none
`include "octp_defs.vh"

module octp_top #(
	parameter QUAL_CYC = `OCTP_QUAL_CYC,
	parameter PULSE_W  = 16
) (
	// clock and reset
	input  wire                    mclk,
	input  wire                    reset_n,
	// contact inputs
	input  wire                    remote_switch_in,
	input  wire                    external_trigger_in,
	input  wire                    isolated_shutdown_in,
	// register port
	input  wire [`OCTP_ADDR_W-1:0] reg_addr,
	input  wire [31:0]             reg_wdata,
	input  wire                    reg_wr,
	input  wire                    reg_rd,
	output reg  [31:0]             reg_rdata,
	// isolated flags, high means transistor conducting
	output reg                     power_good_flag_on,
	output reg                     output_off_flag_on,
	// output stage and indication
	output reg                     output_enable,
	output reg                     fault_indicator_lamp_red,
	output reg                     trigger_event,
	output reg                     irq
);

	// ----------------------------------------------------------------
	// synchronisers
	// ----------------------------------------------------------------
	reg [1:0] rsw_sync_r;
	reg [1:0] trg_sync_r;
	reg [1:0] sd_sync_r;

	// contacts reset to their idle levels (open reads high, optocoupler dark),
	// so releasing reset never shows a false edge to the qualifiers
	// first stage feeds only the second stage
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			rsw_sync_r <= 2'h3;
			trg_sync_r <= 2'h3;
			sd_sync_r  <= 2'h0;
		end else begin
			rsw_sync_r <= {rsw_sync_r[0], remote_switch_in};
			trg_sync_r <= {trg_sync_r[0], external_trigger_in};
			sd_sync_r  <= {sd_sync_r[0], isolated_shutdown_in};
		end
	end

	// synchronised levels, the only copies that the logic below reads
	wire rsw_s = rsw_sync_r[1];
	wire trg_s = trg_sync_r[1];
	wire sd_s  = sd_sync_r[1];

	// ----------------------------------------------------------------
	// control registers
	// ----------------------------------------------------------------
	reg [`OCTP_MODE_W-1:0] mode_r;
	reg                    invert_r;
	reg                    trig_lvl_r;
	reg [PULSE_W-1:0]      pulse_len_r;
	reg                    list_mode_r;
	reg [`OCTP_EV_W-1:0]   irq_stat_r;
	reg [`OCTP_EV_W-1:0]   irq_mask_r;

	wire wr_ctrl  = reg_wr && (reg_addr == `OCTP_REG_CTRL);
	wire wr_cmd   = reg_wr && (reg_addr == `OCTP_REG_CMD);
	wire wr_pulse = reg_wr && (reg_addr == `OCTP_REG_PULSE);
	wire cmd_on   = wr_cmd && reg_wdata[`OCTP_CMD_ON];
	wire cmd_off  = wr_cmd && reg_wdata[`OCTP_CMD_OFF];
	wire cmd_lset = wr_cmd && reg_wdata[`OCTP_CMD_LIST_SET];
	wire cmd_lclr = wr_cmd && reg_wdata[`OCTP_CMD_LIST_CLR];
	wire cmd_tout = wr_cmd && reg_wdata[`OCTP_CMD_TRIG_OUT];

	// the command register keeps no state: each one written is a single
	// cycle strobe, so a repeated write repeats the action
	// configuration writes
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			mode_r      <= `OCTP_MODE_LEVEL;
			invert_r    <= 1'b0;
			trig_lvl_r  <= 1'b1;
			pulse_len_r <= {PULSE_W{1'b0}};
		end else begin
			if (wr_ctrl) begin
				mode_r     <= reg_wdata[`OCTP_CTRL_MODE_LSB +: `OCTP_MODE_W];
				invert_r   <= reg_wdata[`OCTP_CTRL_INVERT];
				trig_lvl_r <= reg_wdata[`OCTP_CTRL_TRIG_LVL];
			end
			if (wr_pulse)
				pulse_len_r <= reg_wdata[PULSE_W-1:0];
		end
	end

	// flag ownership: list setup takes it, list clear gives it back
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n)
			list_mode_r <= 1'b0;
		else if (cmd_lset)
			list_mode_r <= 1'b1;
		else if (cmd_lclr)
			list_mode_r <= 1'b0;
	end

	// ----------------------------------------------------------------
	// qualification counters
	// ----------------------------------------------------------------
	// the counters are 16 bits wide, so the qualify time is limited to 65536
	// cycles; a faster clock or a longer filter needs a wider counter here
	localparam CW = 16;
	localparam integer  QUAL_LAST = QUAL_CYC - 1;
	localparam [CW-1:0] QUAL_MAX  = QUAL_LAST[CW-1:0];

	// remote level after polarity selection, high means enable requested
	wire rsw_en = rsw_s ^ invert_r;

	reg [CW-1:0] rsw_cnt_r;
	reg          rsw_q_r;  // qualified enable level
	reg [CW-1:0] trg_cnt_r;
	reg          trg_armed_r;
	reg          trg_fire;

	// remote level must hold for the qualify time before it is accepted,
	// which also filters contact bounce; well inside the 200 ms bound
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			rsw_cnt_r <= {CW{1'b0}};
			rsw_q_r   <= 1'b1;
		end else if (rsw_en == rsw_q_r) begin
			rsw_cnt_r <= {CW{1'b0}};
		end else if (rsw_cnt_r == QUAL_MAX) begin
			rsw_cnt_r <= {CW{1'b0}};
			rsw_q_r   <= rsw_en;
		end else begin
			rsw_cnt_r <= rsw_cnt_r + 1'b1;
		end
	end

	// a low that lasts far beyond the qualify time still gives one event,
	// because the armed bit stays clear until a synchronised high is seen
	// trigger: one event per low period, rearmed by a high level
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			trg_cnt_r   <= {CW{1'b0}};
			trg_armed_r <= 1'b1;
			trg_fire    <= 1'b0;
		end else begin
			trg_fire <= 1'b0;
			if (trg_s) begin
				trg_cnt_r   <= {CW{1'b0}};
				trg_armed_r <= 1'b1;
			end else if (trg_armed_r) begin
				if (trg_cnt_r == QUAL_MAX) begin
					trg_fire    <= 1'b1;
					trg_armed_r <= 1'b0;
					trg_cnt_r   <= {CW{1'b0}};
				end else begin
					trg_cnt_r <= trg_cnt_r + 1'b1;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// output state
	// ----------------------------------------------------------------
	reg  sd_latch_r;
	reg  standby_r;
	reg  sw_on_r;
	reg  rsw_q_d_r;
	wire rsw_fall = rsw_q_d_r && !rsw_q_r;

	// the synchronised level also forces the output off in the cycle before
	// the latch is set, which shortens the response by a clock
	// shutdown latch is cleared only by power-on reset
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n)
			sd_latch_r <= 1'b0;
		else if (sd_s)
			sd_latch_r <= 1'b1;
	end

	// off wins over on when both bits come in one write, leaving the output
	// in the safe state if a controller sends a confused command
	// commanded state and standby
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			sw_on_r   <= 1'b1;
			standby_r <= 1'b0;
			rsw_q_d_r <= 1'b1;
		end else begin
			rsw_q_d_r <= rsw_q_r;
			if (cmd_off) begin
				sw_on_r <= 1'b0;
			end else if (mode_r == `OCTP_MODE_STANDBY && rsw_fall) begin
				sw_on_r   <= 1'b0;
				standby_r <= 1'b1;
			end else if (cmd_on) begin
				sw_on_r   <= 1'b1;
				standby_r <= 1'b0;
			end
			if (mode_r != `OCTP_MODE_STANDBY && !cmd_off && !cmd_on)
				standby_r <= 1'b0;
		end
	end

	// an unused mode code disables the output rather than guessing
	// effective enable per mode
	reg en_nxt;
	always @* begin
		case (mode_r)
			`OCTP_MODE_LEVEL:   en_nxt = sw_on_r && rsw_q_r;
			`OCTP_MODE_IGNORE:  en_nxt = sw_on_r;
			`OCTP_MODE_STANDBY: en_nxt = sw_on_r;
			default:            en_nxt = 1'b0;
		endcase
		if (sd_latch_r || sd_s)
			en_nxt = 1'b0;
	end

	// ----------------------------------------------------------------
	// trigger output pulse on the output-off flag
	// ----------------------------------------------------------------
	// cycles left in the current trigger pulse
	reg [PULSE_W-1:0] pulse_cnt_r;
	wire              pulse_act = (pulse_cnt_r != {PULSE_W{1'b0}});

	// leaving list mode drops a running pulse, so the flag shows output state
	// again at once instead of finishing a pulse nobody waits for
	// width zero gives no pulse; a new request restarts the count
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n)
			pulse_cnt_r <= {PULSE_W{1'b0}};
		else if (!list_mode_r)
			pulse_cnt_r <= {PULSE_W{1'b0}};
		else if (cmd_tout || trg_fire)
			pulse_cnt_r <= pulse_len_r;
		else if (pulse_act)
			pulse_cnt_r <= pulse_cnt_r - 1'b1;
	end

	// ----------------------------------------------------------------
	// interrupts
	// ----------------------------------------------------------------
	// event strobes, each high for one cycle
	wire [`OCTP_EV_W-1:0] ev;
	assign ev[`OCTP_EV_TRIG]     = trg_fire;
	assign ev[`OCTP_EV_SHUTDOWN] = sd_s && !sd_latch_r;
	assign ev[`OCTP_EV_STANDBY]  = (mode_r == `OCTP_MODE_STANDBY) && rsw_fall;

	wire wr_istat = reg_wr && (reg_addr == `OCTP_REG_IRQ_STAT);
	wire wr_imask = reg_wr && (reg_addr == `OCTP_REG_IRQ_MASK);

	// the shutdown event is raised once, in the cycle that first sets the latch
	// set wins over write-one-to-clear
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			irq_stat_r <= {`OCTP_EV_W{1'b0}};
			irq_mask_r <= {`OCTP_EV_W{1'b0}};
		end else begin
			irq_stat_r <= ev | (irq_stat_r &
				~(wr_istat ? reg_wdata[`OCTP_EV_W-1:0] : {`OCTP_EV_W{1'b0}}));
			if (wr_imask)
				irq_mask_r <= reg_wdata[`OCTP_EV_W-1:0];
		end
	end

	// ----------------------------------------------------------------
	// registered outputs
	// ----------------------------------------------------------------
	// power good and the lamp share one shutdown term, so they never disagree once out of reset;
	// outside list mode the off flag and the enable load from the same next value in the same cycle
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			output_enable            <= 1'b0;
			fault_indicator_lamp_red <= 1'b0;
			power_good_flag_on       <= 1'b0;
			output_off_flag_on       <= 1'b1;
			trigger_event            <= 1'b0;
			irq                      <= 1'b0;
		end else begin
			output_enable            <= en_nxt;
			fault_indicator_lamp_red <= sd_latch_r || sd_s;
			power_good_flag_on       <= !(sd_latch_r || sd_s);
			if (list_mode_r)
				output_off_flag_on <= pulse_act ? trig_lvl_r : !trig_lvl_r;
			else
				output_off_flag_on <= !en_nxt;
			trigger_event <= trg_fire;
			irq           <= |(irq_stat_r & irq_mask_r);
		end
	end

	// ----------------------------------------------------------------
	// register read, data one cycle after the strobe
	// ----------------------------------------------------------------
	// idle cycles return zero, so stale data is never taken for a fresh read
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			reg_rdata <= 32'h00000000;
		end else if (reg_rd) begin
			case (reg_addr)
				`OCTP_REG_CTRL:
					reg_rdata <= {28'h0000000, trig_lvl_r, invert_r, mode_r};
				`OCTP_REG_PULSE:
					reg_rdata <= {{(32-PULSE_W){1'b0}}, pulse_len_r};
				`OCTP_REG_STATUS:
					reg_rdata <= {24'h000000, pulse_act, list_mode_r, trg_armed_r,
						rsw_q_r, standby_r, sd_latch_r, sw_on_r, output_enable};
				`OCTP_REG_IRQ_STAT:
					reg_rdata <= {29'h00000000, irq_stat_r};
				`OCTP_REG_IRQ_MASK:
					reg_rdata <= {29'h00000000, irq_mask_r};
				default:
					reg_rdata <= 32'h00000000;
			endcase
		end else begin
			reg_rdata <= 32'h00000000;
		end
	end

endmodule // octp_top
`default_nettype wire

// file: sim/octp_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// contact-level controller at the rear ports
// ----------------------------------------------------------------
module octp_ctrl_model (
	// clock
	input  wire logic mclk,
	// contacts; an open contact reads high
	output var  logic remote_switch_in,
	output var  logic external_trigger_in,
	output var  logic isolated_shutdown_in
);
	// contacts start open, shutdown optocoupler dark
	initial begin
		remote_switch_in = 1'b1;
		external_trigger_in = 1'b1;
		isolated_shutdown_in = 1'b0;
	end
	// pull the trigger contact low for n clocks, then let it open again
	task automatic trig_low(input int n);
		@(posedge mclk) external_trigger_in <= 1'b0;
		repeat (n) @(posedge mclk);
		external_trigger_in <= 1'b1;
	endtask
	task automatic set_remote(input logic v);
		@(posedge mclk) remote_switch_in <= v;
	endtask
	task automatic set_sd(input logic v);
		@(posedge mclk) isolated_shutdown_in <= v;
	endtask
endmodule // octp_ctrl_model
`default_nettype wire

// file: sim/octp_top_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "octp_defs.vh"
module octp_top_sva #(
	parameter QUAL_CYC = `OCTP_QUAL_CYC
) (
	// clock and reset
	input wire logic        mclk,
	input wire logic        reset_n,
	// contacts
	input wire logic        external_trigger_in,
	input wire logic        isolated_shutdown_in,
	// register port
	input wire logic        reg_rd,
	input wire logic [31:0] reg_rdata,
	// outputs
	input wire logic        power_good_flag_on,
	input wire logic        output_enable,
	input wire logic        fault_indicator_lamp_red,
	input wire logic        trigger_event
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!reset_n);
	// ----------------------------------------------------------------
	// trigger pin history; the last run is kept because the event may
	// land a few cycles after the pin is already back high
	// ----------------------------------------------------------------
	logic [31:0] low_cnt_r;
	logic [31:0] run_r;
	logic        armed_r;
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			low_cnt_r <= 32'h0;
			run_r <= 32'h0;
			armed_r <= 1'b1;
		end else begin
			low_cnt_r <= external_trigger_in ? 32'h0 : low_cnt_r + 32'h1;
			if (external_trigger_in && low_cnt_r != 32'h0)
				run_r <= low_cnt_r;
			if (trigger_event)
				armed_r <= 1'b0;
			else if (external_trigger_in)
				armed_r <= 1'b1;
		end
	end
	sequence s_sd_hit;
		$rose(isolated_shutdown_in);
	endsequence
	sequence s_all_off;
		!output_enable && fault_indicator_lamp_red && !power_good_flag_on;
	endsequence
	a_sd_fast: assert property (s_sd_hit |-> ##[1:4] s_all_off)
		else $error("shutdown late");
	a_sd_latched: assert property (fault_indicator_lamp_red |=> fault_indicator_lamp_red)
		else $error("shutdown released");
	a_lamp_dark: assert property (fault_indicator_lamp_red [*4] |-> !output_enable && !power_good_flag_on)
		else $error("output alive while shut down");
	a_trig_pulse: assert property (trigger_event |=> !trigger_event)
		else $error("trigger pulse too long");
	a_trig_qual: assert property (trigger_event |-> low_cnt_r >= QUAL_CYC || run_r >= QUAL_CYC)
		else $error("trigger on short low");
	a_trig_rearm: assert property (trigger_event |-> armed_r)
		else $error("trigger without rearm");
	a_trig_latency: assert property (low_cnt_r == QUAL_CYC + 8 |-> !armed_r)
		else $error("trigger not answered");
	a_rd_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
		else $error("read data outside read slot");
endmodule // octp_top_sva
bind octp_top octp_top_sva #(.QUAL_CYC(QUAL_CYC)) i_sva (
	.mclk                     (mclk),
	.reset_n                  (reset_n),
	.external_trigger_in      (external_trigger_in),
	.isolated_shutdown_in     (isolated_shutdown_in),
	.reg_rd                   (reg_rd),
	.reg_rdata                (reg_rdata),
	.power_good_flag_on       (power_good_flag_on),
	.output_enable            (output_enable),
	.fault_indicator_lamp_red (fault_indicator_lamp_red),
	.trigger_event            (trigger_event)
);
`default_nettype wire

// file: sim/octp_top_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "octp_defs.vh"
module octp_top_tb_top;
	localparam int Q = 8;
	logic        mclk = 1'b0;
	logic        reset_n = 1'b0;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [3:0]  reg_addr = 4'h0;
	logic [31:0] reg_wdata = 32'h0;
	logic [31:0] reg_rdata;
	logic [31:0] v;
	logic        remote_switch_in, external_trigger_in, isolated_shutdown_in;
	logic        power_good_flag_on, output_off_flag_on, output_enable;
	logic        fault_indicator_lamp_red, trigger_event, irq;
	int          bad_count = 0;
	int          num_checks = 0;
	int          n_ev = 0;
	int          hi;
	always #2.5 mclk = ~mclk;
	// count trigger events as the design reports them
	always @(posedge mclk) if (trigger_event === 1'b1) n_ev <= n_ev + 1;
	octp_top #(.QUAL_CYC(Q)) i_dut (
		.mclk                     (mclk),
		.reset_n                  (reset_n),
		.remote_switch_in         (remote_switch_in),
		.external_trigger_in      (external_trigger_in),
		.isolated_shutdown_in     (isolated_shutdown_in),
		.reg_addr                 (reg_addr),
		.reg_wdata                (reg_wdata),
		.reg_wr                   (reg_wr),
		.reg_rd                   (reg_rd),
		.reg_rdata                (reg_rdata),
		.power_good_flag_on       (power_good_flag_on),
		.output_off_flag_on       (output_off_flag_on),
		.output_enable            (output_enable),
		.fault_indicator_lamp_red (fault_indicator_lamp_red),
		.trigger_event            (trigger_event),
		.irq                      (irq)
	);
	octp_ctrl_model i_ctrl (
		.mclk                 (mclk),
		.remote_switch_in     (remote_switch_in),
		.external_trigger_in  (external_trigger_in),
		.isolated_shutdown_in (isolated_shutdown_in)
	);
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	// waits land 1 ns past the edge so the design's updates have settled
	task automatic wait_cyc(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
	task automatic do_reset;
		@(posedge mclk) reset_n <= 1'b0;
		repeat (4) @(posedge mclk);
		reset_n <= 1'b1;
		wait_cyc(Q);
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		do_reset();
		chk("oe", 32'h1, output_enable);
		chk("pg", 32'h1, power_good_flag_on);
		chk("off_flag", 32'h0, output_off_flag_on);
		rd(`OCTP_REG_CTRL, v);
		chk("ctrl", 32'h8, v);
		rd(4'hF, v);
		chk("unmapped", 32'h0, v);
		// short glitch ignored, long low drops output, polarity inverts
		i_ctrl.set_remote(1'b0);
		wait_cyc(Q / 2);
		i_ctrl.set_remote(1'b1);
		wait_cyc(Q + 10);
		chk("oe_glitch", 32'h1, output_enable);
		i_ctrl.set_remote(1'b0);
		wait_cyc(Q + 10);
		chk("oe_low", 32'h0, output_enable);
		chk("flag_low", 32'h1, output_off_flag_on);
		wr(`OCTP_REG_CTRL, 32'hC);
		wait_cyc(Q + 10);
		chk("oe_inv", 32'h1, output_enable);
		i_ctrl.set_remote(1'b1);
		wait_cyc(Q + 10);
		chk("oe_inv_hi", 32'h0, output_enable);
		$display("test remote done");
		// ignore mode: only commands move the output
		wr(`OCTP_REG_CTRL, 32'h9);
		i_ctrl.set_remote(1'b0);
		wait_cyc(Q + 10);
		chk("oe_ign", 32'h1, output_enable);
		wr(`OCTP_REG_CMD, 32'h2);
		wait_cyc(3);
		chk("oe_cmd_off", 32'h0, output_enable);
		wr(`OCTP_REG_CMD, 32'h1);
		wait_cyc(3);
		chk("oe_cmd_on", 32'h1, output_enable);
		// standby: low disables, high does not restore, on command does
		wr(`OCTP_REG_CTRL, 32'hA);
		i_ctrl.set_remote(1'b1);
		wait_cyc(Q + 10);
		i_ctrl.set_remote(1'b0);
		wait_cyc(Q + 10);
		chk("oe_sby", 32'h0, output_enable);
		rd(`OCTP_REG_STATUS, v);
		chk("sby_bit", 32'h1, v[3]);
		rd(`OCTP_REG_IRQ_STAT, v);
		chk("sby_irq", 32'h4, v);
		i_ctrl.set_remote(1'b1);
		wait_cyc(Q + 10);
		chk("oe_sby_hi", 32'h0, output_enable);
		wr(`OCTP_REG_CMD, 32'h1);
		wait_cyc(3);
		chk("oe_sby_on", 32'h1, output_enable);
		wr(`OCTP_REG_CTRL, 32'h8);
		$display("test modes done");
		// trigger qualification, single event per low, interrupt path
		wr(`OCTP_REG_IRQ_STAT, 32'h7);
		wr(`OCTP_REG_IRQ_MASK, 32'h1);
		i_ctrl.trig_low(Q / 2);
		wait_cyc(Q + 10);
		chk("ev_short", 32'h0, n_ev);
		i_ctrl.trig_low(3 * Q);
		wait_cyc(Q + 10);
		chk("ev_long", 32'h1, n_ev);
		chk("irq_set", 32'h1, irq);
		wr(`OCTP_REG_IRQ_MASK, 32'h0);
		wait_cyc(2);
		chk("irq_mask", 32'h0, irq);
		wr(`OCTP_REG_IRQ_MASK, 32'h1);
		wr(`OCTP_REG_IRQ_STAT, 32'h1);
		wait_cyc(2);
		chk("irq_clr", 32'h0, irq);
		i_ctrl.trig_low(3 * Q);
		wait_cyc(Q + 10);
		chk("ev_rearm", 32'h2, n_ev);
		$display("test trigger done");
		// list mode: flag becomes a trigger output of set level and width
		wr(`OCTP_REG_CMD, 32'h2);
		wr(`OCTP_REG_PULSE, 32'h5);
		wr(`OCTP_REG_CMD, 32'h4);
		wait_cyc(3);
		chk("flag_list", 32'h0, output_off_flag_on);
		for (int l = 0; l < 2; l++) begin
			wr(`OCTP_REG_CTRL, l ? 32'h0 : 32'h8);
			wr(`OCTP_REG_CMD, 32'h10);
			hi = 0;
			repeat (20) begin
				wait_cyc(1);
				hi += (output_off_flag_on === (l ? 1'b0 : 1'b1));
			end
			chk("pulse_len", 32'h5, hi);
		end
		wr(`OCTP_REG_CMD, 32'h8);
		wait_cyc(3);
		chk("flag_clr", 32'h1, output_off_flag_on);
		wr(`OCTP_REG_CTRL, 32'h8);
		wr(`OCTP_REG_CMD, 32'h1);
		$display("test list done");
		// isolated shutdown latches until reset
		wr(`OCTP_REG_IRQ_MASK, 32'h2);
		i_ctrl.set_sd(1'b1);
		wait_cyc(4);
		chk("sd_oe", 32'h0, output_enable);
		chk("sd_lamp", 32'h1, fault_indicator_lamp_red);
		chk("sd_pg", 32'h0, power_good_flag_on);
		chk("sd_irq", 32'h1, irq);
		i_ctrl.set_sd(1'b0);
		wr(`OCTP_REG_CMD, 32'h1);
		wait_cyc(Q);
		chk("sd_held", 32'h0, output_enable);
		do_reset();
		chk("sd_gone", 32'h0, fault_indicator_lamp_red);
		chk("oe_back", 32'h1, output_enable);
		$display("test shutdown done");
		test_done();
	end
endmodule // octp_top_tb_top
`default_nettype wire
